// ===== fsp_pkg.sv
package fsp_pkg;

    // Clock and flash bus cycle timing (least times, rounded up)
    localparam int CLOCK_MHZ    = 10;
    localparam int T_SETUP_NS   = 100;
    localparam int T_PULSE_NS   = 150;
    localparam int T_RECOVER_NS = 100;
    localparam int SETUP_CYC    = (T_SETUP_NS * CLOCK_MHZ + 999) / 1000;
    localparam int PULSE_CYC    = (T_PULSE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC  = (T_RECOVER_NS * CLOCK_MHZ + 999) / 1000;

    // Flash bus widths
    localparam int FLASH_AW = 21;
    localparam int FLASH_DW = 16;

    // Own register offsets on the AXI4-Lite side
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_ADDR  = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STAT  = 8'h0c;
    localparam logic [7:0] REG_SR    = 8'h10;
    localparam logic [7:0] REG_XSR   = 8'h14;
    localparam logic [7:0] REG_PCR   = 8'h18;

    // Control and status field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int CTRL_OP_LSB    = 4;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DONE_BIT  = 1;
    localparam int STAT_ERR_BIT   = 2;

    // Flash status, extended status and partition layout fields
    localparam int              SR_READY_BIT   = 7;
    localparam logic [15:0]     SR_USE_MASK    = 16'h00fe;
    localparam int              XSR_AVAIL_BIT  = 7;
    localparam logic [15:0]     XSR_USE_MASK   = 16'h0080;
    localparam logic [15:0]     PCR_USE_MASK   = 16'h0700;
    localparam int              PCR_LSB        = 8;
    localparam int              PCR_COUNT_LSB  = 16;
    localparam int              PCR_DUAL_BIT   = 19;

    // AXI responses
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        OP_STATUS = 2'b00,
        OP_BUFCHK = 2'b01,
        OP_PCR    = 2'b10,
        OP_RAW    = 2'b11
    } fsp_op_t;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_CMD  = 2'b01,
        SQ_READ = 2'b10
    } fsp_seq_t;

    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_SETUP   = 2'b01,
        PH_PULSE   = 2'b10,
        PH_RECOVER = 2'b11
    } fsp_phase_t;

    // Flash pin bundle, all active-low strobes
    typedef struct packed {
        logic [FLASH_AW-1:0] addr;
        logic [FLASH_DW-1:0] dq_out;
        logic                dq_oe;
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
    } fsp_pins_t;

    // One flash bus cycle request
    typedef struct packed {
        logic                go;
        logic                write;
        logic [FLASH_AW-1:0] addr;
        logic [FLASH_DW-1:0] data;
    } fsp_req_t;

    // Partitions formed by a layout code
    function automatic logic [2:0] fsp_part_count(input logic [2:0] code);
        case (code)
            3'h0:                fsp_part_count = 3'h1;
            3'h1, 3'h2, 3'h4:    fsp_part_count = 3'h2;
            3'h3, 3'h6, 3'h5:    fsp_part_count = 3'h3;
            default:             fsp_part_count = 3'h4;
        endcase
    endfunction : fsp_part_count

endpackage : fsp_pkg

// ===== fsp_bus_cycle.sv
`timescale 1ns/1ps
module fsp_bus_cycle
    import fsp_pkg::*;
(
    // Clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_rst_n,
    // Cycle request and answer
    input  wire fsp_req_t            i_req,
    output logic                     o_done,
    output logic [FLASH_DW-1:0]      o_rdata,
    // Flash pins
    input  wire logic [FLASH_DW-1:0] i_dq,
    output fsp_pins_t                o_pins
);

    if (SETUP_CYC > 255 || PULSE_CYC > 255 || RECOVER_CYC > 255)
        $error("bus cycle timing does not fit the phase counter");

    typedef struct packed {
        fsp_phase_t          phase;
        logic [7:0]          cnt;
        logic                write;
        fsp_pins_t           pins;
        logic [FLASH_DW-1:0] rdata;
        logic                done;
    } fsp_cyc_state_t;

    fsp_cyc_state_t s;
    fsp_cyc_state_t next_s;

    // Setup, strobe and recovery phases of one asynchronous cycle
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.phase)
            PH_IDLE: begin
                if (i_req.go) begin
                    next_s.phase       = PH_SETUP;
                    next_s.cnt         = 8'(SETUP_CYC - 1);
                    next_s.write       = i_req.write;
                    next_s.pins.addr   = i_req.addr;
                    next_s.pins.dq_out = i_req.data;
                    next_s.pins.ce_n   = 1'b0;
                    next_s.pins.dq_oe  = i_req.write;
                end
            end
            PH_SETUP: begin
                if (s.cnt == 8'h00) begin
                    next_s.phase     = PH_PULSE;
                    next_s.cnt       = 8'(PULSE_CYC - 1);
                    next_s.pins.we_n = !s.write;
                    next_s.pins.oe_n = s.write;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            PH_PULSE: begin
                if (s.cnt == 8'h00) begin
                    // Sample read data while output enable is still low
                    if (!s.write)
                        next_s.rdata = i_dq;
                    next_s.phase     = PH_RECOVER;
                    next_s.cnt       = 8'(RECOVER_CYC - 1);
                    next_s.pins.we_n = 1'b1;
                    next_s.pins.oe_n = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            PH_RECOVER: begin
                // Data held past the rising strobe, then chip released
                next_s.pins.dq_oe = 1'b0;
                next_s.pins.ce_n  = 1'b1;
                if (s.cnt == 8'h00) begin
                    next_s.phase = PH_IDLE;
                    next_s.done  = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '{phase: PH_IDLE, cnt: 8'h00, write: 1'b0,
                   pins: '{addr: '0, dq_out: '0, dq_oe: 1'b0,
                           ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1},
                   rdata: '0, done: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign o_done  = s.done;
    assign o_rdata = s.rdata;
    assign o_pins  = s.pins;

    // Write strobe lasts the full pulse with output enable held high
    property p_strobe_len;
        @(posedge i_clock) disable iff (!i_rst_n)
        $fell(s.pins.we_n) |-> (!s.pins.we_n && s.pins.oe_n)[*2]
            ##1 s.pins.we_n;
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("write strobe length wrong");

endmodule : fsp_bus_cycle

// ===== fsp_host.sv
// Function
// - Host ignores status bits 6 to 0 until ready bit reads 1.
// - Host masks status bits 15 to 8 and bit 0 when polling.
// - Host checks buffer-available bit and reissues the command if 0, up to RETRY_MAX times.
// - Host detects completion by polling the ready bit.
// - Identifier data is read within the partition chosen by the command.
`timescale 1ns/1ps
module fsp_host
    import fsp_pkg::*;
#(
    parameter logic [15:0]         CMD_READ_STATUS = 16'h0070,
    parameter logic [15:0]         CMD_READ_ID     = 16'h0090,
    parameter logic [15:0]         CMD_BUF_PROG    = 16'h00e8,
    parameter logic [FLASH_AW-1:0] PCR_ID_OFFSET   = 21'h000006,
    parameter int                  RETRY_MAX       = 16
) (
    // Clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_rst_n,
    // AXI4-Lite write channels
    input  wire logic [7:0]          i_awaddr,
    input  wire logic                i_awvalid,
    output logic                     o_awready,
    input  wire logic [31:0]         i_wdata,
    input  wire logic [3:0]          i_wstrb,
    input  wire logic                i_wvalid,
    output logic                     o_wready,
    output logic [1:0]               o_bresp,
    output logic                     o_bvalid,
    input  wire logic                i_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]          i_araddr,
    input  wire logic                i_arvalid,
    output logic                     o_arready,
    output logic [31:0]              o_rdata,
    output logic [1:0]               o_rresp,
    output logic                     o_rvalid,
    input  wire logic                i_rready,
    // Flash pins
    input  wire logic [FLASH_DW-1:0] i_dq,
    output fsp_pins_t                o_pins
);

    if (RETRY_MAX < 1 || RETRY_MAX > 255)
        $error("RETRY_MAX must lie in 1..255");

    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                aw_ok;
        logic                w_ok;
        logic [7:0]          waddr;
        logic [31:0]         wbuf;
        logic [3:0]          wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
        fsp_seq_t            seq;
        fsp_op_t             op;
        logic                busy;
        logic                done;
        logic                err;
        logic [7:0]          retries;
        logic [FLASH_AW-1:0] addr;
        logic [FLASH_DW-1:0] wdata;
        logic [FLASH_DW-1:0] sr;
        logic [FLASH_DW-1:0] extended_status_word;
        logic [FLASH_DW-1:0] partition_layout_config;
        fsp_req_t            req;
    } fsp_host_state_t;

    fsp_host_state_t     s;
    fsp_host_state_t     next_s;
    logic                cyc_done;
    logic [FLASH_DW-1:0] cyc_rdata;
    logic [2:0]          layout;

    // Merge a write into a register by byte lanes
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                old[8*i +: 8] = nw[8*i +: 8];
        end
        return old;
    endfunction : lane_merge

    assign layout = s.partition_layout_config[PCR_LSB +: 3];

    // Bus slave, register writes and the flash command sequencer
    always_comb begin
        logic [31:0] merged;
        logic        start;
        merged = 32'h0000_0000;
        start  = 1'b0;
        next_s = s;
        next_s.req.go = 1'b0;
        if (i_awvalid && s.awready) begin
            next_s.aw_ok = 1'b1;
            next_s.waddr = i_awaddr;
        end
        if (i_wvalid && s.wready) begin
            next_s.w_ok  = 1'b1;
            next_s.wbuf  = i_wdata;
            next_s.wstrb = i_wstrb;
        end
        if (s.bvalid && i_bready)
            next_s.bvalid = 1'b0;
        // Commit once both address and data are held
        if (s.aw_ok && s.w_ok && !s.bvalid) begin
            next_s.aw_ok  = 1'b0;
            next_s.w_ok   = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = AXI_OKAY;
            unique case (s.waddr)
                REG_CTRL: begin
                    if (s.wstrb[0]) begin
                        if (s.wbuf[CTRL_CLEAR_BIT]) begin
                            next_s.done = 1'b0;
                            next_s.err  = 1'b0;
                        end
                        // A start while busy is dropped
                        start = s.wbuf[CTRL_START_BIT] && !s.busy;
                    end
                end
                REG_ADDR: begin
                    merged = lane_merge(32'(s.addr), s.wbuf, s.wstrb);
                    next_s.addr = merged[FLASH_AW-1:0];
                end
                REG_WDATA: begin
                    merged = lane_merge(32'(s.wdata), s.wbuf, s.wstrb);
                    next_s.wdata = merged[FLASH_DW-1:0];
                end
                REG_STAT, REG_SR, REG_XSR, REG_PCR: ;
                default: next_s.bresp = AXI_SLVERR;
            endcase
        end
        next_s.awready = !next_s.aw_ok && !next_s.bvalid;
        next_s.wready  = !next_s.w_ok && !next_s.bvalid;

        // Read channel answers one cycle after the address is taken
        if (s.rvalid && i_rready)
            next_s.rvalid = 1'b0;
        if (i_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = AXI_OKAY;
            unique case (i_araddr)
                REG_CTRL:  next_s.rdata = 32'(s.op) << CTRL_OP_LSB;
                REG_ADDR:  next_s.rdata = 32'(s.addr);
                REG_WDATA: next_s.rdata = 32'(s.wdata);
                REG_STAT:  next_s.rdata = 32'({s.err, s.done, s.busy});
                REG_SR:    next_s.rdata = 32'(s.sr);
                REG_XSR:   next_s.rdata = 32'(s.extended_status_word);
                REG_PCR: begin
                    next_s.rdata = 32'(s.partition_layout_config);
                    next_s.rdata[PCR_COUNT_LSB +: 3] =
                        fsp_part_count(layout);
                    next_s.rdata[PCR_DUAL_BIT] = (layout != 3'h0);
                end
                default: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = AXI_SLVERR;
                end
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // Flash sequencer: command cycle, then one or more read cycles (none for OP_RAW)
        unique case (s.seq)
            SQ_IDLE: begin
                if (start) begin
                    next_s.op      = fsp_op_t'(s.wbuf[CTRL_OP_LSB +: 2]);
                    next_s.busy    = 1'b1;
                    next_s.done    = 1'b0;
                    next_s.err     = 1'b0;
                    next_s.retries = 8'h00;
                    next_s.seq     = SQ_CMD;
                    next_s.req.go    = 1'b1;
                    next_s.req.write = 1'b1;
                    next_s.req.addr  = s.addr;
                    unique case (fsp_op_t'(s.wbuf[CTRL_OP_LSB +: 2]))
                        OP_STATUS: next_s.req.data = CMD_READ_STATUS;
                        OP_BUFCHK: next_s.req.data = CMD_BUF_PROG;
                        OP_PCR:    next_s.req.data = CMD_READ_ID;
                        OP_RAW:    next_s.req.data = s.wdata;
                    endcase
                end
            end
            SQ_CMD: begin
                if (cyc_done) begin
                    if (s.op == OP_RAW) begin
                        next_s.seq  = SQ_IDLE;
                        next_s.busy = 1'b0;
                        next_s.done = 1'b1;
                    end else begin
                        next_s.seq       = SQ_READ;
                        next_s.req.go    = 1'b1;
                        next_s.req.write = 1'b0;
                        // Stay inside the partition the command chose
                        next_s.req.addr  = (s.op == OP_PCR) ?
                            s.addr + PCR_ID_OFFSET : s.addr;
                    end
                end
            end
            SQ_READ: begin
                if (cyc_done) begin
                    unique case (s.op)
                        OP_STATUS: begin
                            if (!cyc_rdata[SR_READY_BIT]) begin
                                // Low bits are not valid yet: poll again
                                next_s.req.go = 1'b1;
                            end else begin
                                next_s.sr   = cyc_rdata & SR_USE_MASK;
                                next_s.seq  = SQ_IDLE;
                                next_s.busy = 1'b0;
                                next_s.done = 1'b1;
                            end
                        end
                        OP_BUFCHK: begin
                            next_s.extended_status_word = cyc_rdata & XSR_USE_MASK;
                            if (!cyc_rdata[XSR_AVAIL_BIT] &&
                                s.retries < 8'(RETRY_MAX)) begin
                                // Rejected: reissue the buffer command
                                next_s.retries   = s.retries + 8'h01;
                                next_s.seq       = SQ_CMD;
                                next_s.req.go    = 1'b1;
                                next_s.req.write = 1'b1;
                                next_s.req.addr  = s.addr;
                            end else begin
                                next_s.err  = !cyc_rdata[XSR_AVAIL_BIT];
                                next_s.seq  = SQ_IDLE;
                                next_s.busy = 1'b0;
                                next_s.done = 1'b1;
                            end
                        end
                        default: begin
                            next_s.partition_layout_config  = cyc_rdata & PCR_USE_MASK;
                            next_s.seq  = SQ_IDLE;
                            next_s.busy = 1'b0;
                            next_s.done = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                next_s.seq  = SQ_IDLE;
                next_s.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // One asynchronous flash bus cycle at a time
    fsp_bus_cycle u_cycle (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_req   (s.req),
        .o_done  (cyc_done),
        .o_rdata (cyc_rdata),
        .i_dq    (i_dq),
        .o_pins  (o_pins)
    );

    assign o_awready = s.awready;
    assign o_wready  = s.wready;
    assign o_bresp   = s.bresp;
    assign o_bvalid  = s.bvalid;
    assign o_arready = s.arready;
    assign o_rdata   = s.rdata;
    assign o_rresp   = s.rresp;
    assign o_rvalid  = s.rvalid;

    property p_poll_busy;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s.seq == SQ_READ && s.op == OP_STATUS && cyc_done &&
         !cyc_rdata[SR_READY_BIT])
            |=> s.seq == SQ_READ && s.busy && s.req.go && $stable(s.sr);
    endproperty
    a_poll_busy: assert property (p_poll_busy)
        else $error("status taken while engine busy");

    property p_poll_ready;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s.seq == SQ_READ && s.op == OP_STATUS && cyc_done &&
         cyc_rdata[SR_READY_BIT]) |=> !s.busy && s.done;
    endproperty
    a_poll_ready: assert property (p_poll_ready)
        else $error("ready status did not end the poll");

    property p_sr_masked;
        @(posedge i_clock) disable iff (!i_rst_n)
        $changed(s.sr) |-> (s.sr & ~SR_USE_MASK) == 16'h0000 &&
            s.sr == ($past(cyc_rdata) & SR_USE_MASK);
    endproperty
    a_sr_masked: assert property (p_sr_masked)
        else $error("reserved status bits kept");

    property p_retry;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s.seq == SQ_READ && s.op == OP_BUFCHK && cyc_done &&
         !cyc_rdata[XSR_AVAIL_BIT] && s.retries < 8'(RETRY_MAX))
            |=> s.seq == SQ_CMD && s.req.go && s.req.write &&
                s.req.data == CMD_BUF_PROG ##[1:40] o_pins.we_n == 1'b0;
    endproperty
    a_retry: assert property (p_retry)
        else $error("rejected buffer command not reissued");

    property p_id_partition;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s.seq == SQ_CMD && s.op == OP_PCR && cyc_done)
            |=> s.req.go && !s.req.write &&
                s.req.addr == s.addr + PCR_ID_OFFSET;
    endproperty
    a_id_partition: assert property (p_id_partition)
        else $error("identifier read left the partition");

    property p_write_answer;
        @(posedge i_clock) disable iff (!i_rst_n)
        (s.aw_ok && s.w_ok && !s.bvalid) |=> s.bvalid ##0 !s.awready;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response missing");

endmodule : fsp_host

// ===== fsp_flash_model.sv
`timescale 1ns/1ps
module fsp_flash_model
    import fsp_pkg::*;
(
    // Flash pins from the host
    input  wire fsp_pins_t           i_pins,
    // Device condition chosen by the bench
    input  wire logic [15:0]         i_status,
    input  wire logic [2:0]          i_layout,
    input  wire logic [3:0]          i_wait,
    // Data bus back to the host
    output logic [FLASH_DW-1:0]      o_dq
);
    logic [15:0] cmd   = 16'h00ff;
    logic [3:0]  polls = 4'h0;
    logic [15:0] last  = 16'h0000;
    logic [15:0] ans;
    // Command latched at the end of the write strobe
    always @(posedge i_pins.we_n) begin
        if (!i_pins.ce_n) begin
            cmd = i_pins.dq_out;
            polls = 4'h0;
        end
    end
    // Each read pulse counts one poll of the engine
    always @(negedge i_pins.oe_n) polls = polls + 4'h1;
    always @(posedge i_pins.oe_n) last = ans;
    // Reserved identifier bits read as ones; busy status carries junk low bits
    assign ans = (cmd == 16'h0090) ? {5'h1f, i_layout, 8'hff}
               : (polls <= i_wait) ? 16'h007f
               : i_status;
    // Released bus shows the inverse, never a stale copy
    assign o_dq = (!i_pins.oe_n && !i_pins.ce_n) ? ans : ~last;
endmodule : fsp_flash_model

// ===== flash_status_partition_regs_tb_top.sv
`timescale 1ns/1ps
module flash_status_partition_regs_tb_top;
    import fsp_pkg::*;
    logic i_clock = 0, i_rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0;
    logic rry = 0, awr, wr, bv, arr, rv;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd, d;
    logic [1:0] br, rr, r;
    logic [15:0] st = 16'h0080, fdq;
    logic [2:0] lay = 3'h1;
    logic [3:0] wt = 4'h0;
    fsp_pins_t pins;
    int err_total = 0, num_checks = 0;
    // 100 ns clock
    always #50 i_clock = ~i_clock;
    fsp_host #(.RETRY_MAX(2)) DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
        .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr), .o_bresp(br),
        .o_bvalid(bv), .i_bready(bry), .i_araddr(ara), .i_arvalid(arv),
        .o_arready(arr), .o_rdata(rd), .o_rresp(rr), .o_rvalid(rv),
        .i_rready(rry), .i_dq(fdq), .o_pins(pins));
    fsp_flash_model FLASH (.i_pins(pins), .i_status(st), .i_layout(lay),
        .i_wait(wt), .o_dq(fdq));
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk_val
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        chk_val({30'h0, g}, {30'h0, e});
    endtask : chk_resp
    // Address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clock);
        awa <= a;
        wd  <= v;
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr)
                wv <= 1'b0;
            if (bv) begin
                r = br;
                bry <= 1'b0;
                break;
            end
        end
    endtask : axw
    // Read data and response taken at the edge that sees rvalid
    task automatic axr(input logic [7:0] a);
        @(posedge i_clock);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        forever begin
            @(posedge i_clock);
            if (arv && arr)
                arv <= 1'b0;
            if (rv) begin
                d = rd;
                r = rr;
                rry <= 1'b0;
                break;
            end
        end
    endtask : axr
    // Start an operation and poll until the done flag shows
    task automatic run(input logic [1:0] op, input logic [31:0] stat);
        axw(REG_CTRL, {26'h0, op, 4'h1});
        do axr(REG_STAT); while (d[STAT_DONE_BIT] !== 1'b1);
        chk_val(d, stat);
        axw(REG_CTRL, 32'h2);
    endtask : run
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        #3000000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        // Layout copy is zero before any read: one partition, no dual work
        axr(REG_PCR);
        chk_val(d, 32'h0001_0000);
        chk_resp(r, AXI_OKAY);
        axr(8'h1c);
        chk_resp(r, AXI_SLVERR);
        axw(8'h1c, 32'h0);
        chk_resp(r, AXI_SLVERR);
        // Partition base and raw word read back, then a raw command cycle
        axw(REG_ADDR, 32'h0010_0000);
        axw(REG_WDATA, 32'h0000_00ff);
        axr(REG_ADDR);
        chk_val(d, 32'h0010_0000);
        axr(REG_WDATA);
        chk_val(d, 32'h0000_00ff);
        run(2'h3, 32'h2);
        axr(REG_CTRL);
        chk_val(d, 32'h0000_0030);
        // Two busy polls with junk low bits, then each flag alone
        wt <= 4'h2;
        for (int i = 1; i < 7; i++) begin
            st <= 16'hff80 | (16'h1 << i);
            run(2'h0, 32'h2);
            axr(REG_SR);
            chk_val(d, {16'h0, st & 16'h00fe});
        end
        st <= 16'hffb1;
        run(2'h0, 32'h2);
        axr(REG_SR);
        chk_val(d, 32'h0000_00b0);
        // Buffer available at once, then never
        st <= 16'hff80;
        wt <= 4'h0;
        run(2'h1, 32'h2);
        axr(REG_XSR);
        chk_val(d, 32'h0000_0080);
        wt <= 4'hf;
        run(2'h1, 32'h6);
        // Every layout code
        for (int c = 0; c < 8; c++) begin
            lay <= c[2:0];
            run(2'h2, 32'h2);
            axr(REG_PCR);
            chk_val(d, {12'h0, c != 0, (c == 0) ? 3'h1 : (c == 7) ? 3'h4
                : (c == 3 || c == 5 || c == 6) ? 3'h3 : 3'h2, 5'h0, c[2:0],
                8'h0});
        end
        wrap_up();
    end
endmodule : flash_status_partition_regs_tb_top
